/* rct_timer.sv */
// Top level of the reload/capture PWM timer with its APB register slave.
`timescale 1ns/1ps
`default_nettype none
module rct_timer #(
  parameter int unsigned PSC_W = 7
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [rct_pkg::RCT_AW-1:0] paddr_i,
  input  wire logic [rct_pkg::RCT_DW-1:0] pwdata_i,
  output logic      [rct_pkg::RCT_DW-1:0] prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      event_in_pin_i,
  output logic                           pwm_out_pin_o,
  output logic                           irq_o
);
  import rct_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [7:0]       mode_q;
  logic [2:0]       flags_q;
  logic [7:0]       clkcfg_q;
  logic [7:0]       reload_q;
  logic [7:0]       cmp_q;
  logic [7:0]       cnt_q;
  logic [7:0]       cnt_d;
  logic             pwm_q;
  logic             pin_q;
  logic             irq_q;
  logic             pready_q;
  logic             pslverr_q;
  logic [RCT_DW-1:0] prdata_q;
  logic [RCT_DW-1:0] rd_mux;

  logic             setup;
  logic             wr;
  logic [7:0]       wdat;
  logic             wr_mode;
  logic             wr_flags;
  logic             wr_clkcfg;
  logic             wr_reload;
  logic             wr_cmp;
  logic             wr_load;
  rct_mode_t        mode;
  logic             load_bit;
  logic             same_rewrite;
  logic             rise;
  logic             fall;
  logic             edge_ev;
  logic             cap_ev;
  logic             cap_rst;
  logic             ext_ld;
  logic             load_rr;
  logic             any_load;
  logic             tick;
  logic             count_ev;
  logic             wrap_ev;
  logic             match_ev;
  logic             reload_ovf;
  logic             psc_clear;
  logic [2:0]       set_vec;
  logic [PSC_W-1:0] psc;

  function automatic logic hit(input logic [RCT_AW-1:0] a, input logic [RCT_AW-1:0] t);
    hit = (a == t);
  endfunction : hit

  function automatic logic known(input logic [RCT_AW-1:0] a);
    known = hit(a, RCT_ADDR_MODE) | hit(a, RCT_ADDR_FLAGS) | hit(a, RCT_ADDR_CLKCFG) |
            hit(a, RCT_ADDR_RELOAD) | hit(a, RCT_ADDR_CMP) | hit(a, RCT_ADDR_LOAD);
  endfunction : known

  ////////////////////////////////////////////////////////////////////////////
  // APB slave.

  assign setup     = psel_i & ~penable_i;
  assign wr        = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
  assign wdat      = pwdata_i[7:0];
  assign wr_mode   = wr & hit(paddr_i, RCT_ADDR_MODE);
  assign wr_flags  = wr & hit(paddr_i, RCT_ADDR_FLAGS);
  assign wr_clkcfg = wr & hit(paddr_i, RCT_ADDR_CLKCFG);
  assign wr_reload = wr & hit(paddr_i, RCT_ADDR_RELOAD);
  assign wr_cmp    = wr & hit(paddr_i, RCT_ADDR_CMP);
  assign wr_load   = wr & hit(paddr_i, RCT_ADDR_LOAD);

  always_comb begin
    rd_mux = '0;
    case (1'b1)
      // (R16) Load bit reads as zero.
      hit(paddr_i, RCT_ADDR_MODE):   rd_mux[7:0] = {1'b0, mode_q[6:0]};
      // (R21) Upper flag bits read zero.
      hit(paddr_i, RCT_ADDR_FLAGS):  rd_mux[2:0] = flags_q;
      hit(paddr_i, RCT_ADDR_CLKCFG): rd_mux[7:0] = clkcfg_q;
      hit(paddr_i, RCT_ADDR_RELOAD): rd_mux[7:0] = reload_q;
      hit(paddr_i, RCT_ADDR_CMP):    rd_mux[7:0] = cmp_q;
      hit(paddr_i, RCT_ADDR_LOAD):   rd_mux[7:0] = cnt_q;
      default:                       rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup & ~pready_q;
      pslverr_q <= setup & ~known(paddr_i);
      if (setup) begin
        prdata_q <= pwrite_i ? '0 : rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // (R14) Mode register cleared by reset.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= RCT_MODE_RST;
    end else if (wr_mode) begin
      mode_q <= {1'b0, wdat[6:0]};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clkcfg_q <= RCT_DATA_RST;
      cmp_q    <= RCT_DATA_RST;
    end else begin
      if (wr_clkcfg) begin
        clkcfg_q <= {wdat[7:5], 1'b0, wdat[3:0]};
      end
      if (wr_cmp) begin
        cmp_q <= wdat;
      end
    end
  end

  // (R20) Mode field decode.
  assign mode = rct_mode_t'(mode_q[1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Event input and clock chain.

  rct_edge_det u_rct_edge_det (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (event_in_pin_i),
    .rise_o    (rise),
    .fall_o    (fall)
  );

  // (R25) Edge enable and polarity.
  assign edge_ev = clkcfg_q[RCT_CC_EDGE] & (clkcfg_q[RCT_CC_POL] ? fall : rise);

  rct_prescaler #(
    .PSC_W (PSC_W)
  ) u_rct_prescaler (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .run_i      (mode_q[RCT_MC_EN]),
    .clear_i    (psc_clear),
    .src_i      (rct_src_t'(clkcfg_q[1:0])),
    .ratio_i    (clkcfg_q[RCT_CC_PS_HI:RCT_CC_PS_LO]),
    .ext_tick_i (rise),
    .tick_o     (tick),
    .psc_o      (psc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter.

  // (R16) Load bit copies reload value.
  assign load_bit     = wr_mode & wdat[RCT_MC_LOAD];
  // (R15) Same-value rewrite restarts count while enable and PWM output enable are both set.
  assign same_rewrite = wr_mode & ~wdat[RCT_MC_LOAD] & (wdat[6:0] == mode_q[6:0]) &
                        mode_q[RCT_MC_EN] & mode_q[RCT_MC_PWM_OUT_ENABLE];
  assign cap_ev       = edge_ev & ((mode == RCT_MODE_CAPTURE) | (mode == RCT_MODE_CAP_RST));
  // (R8) Capture also resets counter.
  assign cap_rst      = edge_ev & (mode == RCT_MODE_CAP_RST);
  // (R10) External edge loads counter.
  assign ext_ld       = edge_ev & (mode == RCT_MODE_EXT_LD);
  assign load_rr      = load_bit | same_rewrite | ext_ld;
  assign any_load     = wr_load | load_rr | cap_rst;
  assign count_ev     = tick & ~any_load;
  assign wrap_ev      = count_ev & (cnt_q == RCT_CNT_MAX);
  // (R23) Overflow reloads in auto-reload.
  assign reload_ovf   = wrap_ev & (mode == RCT_MODE_RELOAD);
  // (R12) Every load clears prescaler.
  assign psc_clear    = any_load | reload_ovf;

  always_comb begin
    cnt_d = cnt_q;
    if (wr_load) begin
      cnt_d = wdat;
    end else if (load_rr) begin
      cnt_d = reload_q;
    end else if (cap_rst) begin
      cnt_d = RCT_DATA_RST;
    end else if (reload_ovf) begin
      cnt_d = reload_q;
    end else if (count_ev) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  // (R17) Counter only counts on ticks.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= RCT_DATA_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // (R5) Capture counter on active edge.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_q <= RCT_DATA_RST;
    end else if (cap_ev) begin
      reload_q <= cnt_q;
    end else if (wr_reload) begin
      reload_q <= wdat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, PWM and interrupt.

  assign match_ev = count_ev & (cnt_d == cmp_q);
  // (R22) Flag sources.
  assign set_vec  = {edge_ev, match_ev, wrap_ev};

  // (R21) Zero clears, one keeps, set wins.
  // (R13) Writing 06h clears only wrap flag.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_q <= RCT_FLAGS_RST;
    end else begin
      flags_q <= (flags_q & (wr_flags ? wdat[2:0] : 3'h7)) | set_vec;
    end
  end

  // (R6) Match drives low, overflow high.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_q <= 1'b0;
    end else if (match_ev) begin
      pwm_q <= 1'b0;
    end else if (wrap_ev) begin
      pwm_q <= 1'b1;
    end
  end

  // (R18) Output enable gates the pin.
  // (R19) Interrupt from enable and flag.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      pin_q <= mode_q[RCT_MC_PWM_OUT_ENABLE] & pwm_q;
      irq_q <= |(flags_q & mode_q[RCT_MC_IRQ_HI:RCT_MC_IRQ_LO]);
    end
  end

  assign prdata_o      = prdata_q;
  assign pready_o      = pready_q;
  assign pslverr_o     = pslverr_q;
  assign pwm_out_pin_o = pin_q;
  assign irq_o         = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_load_bit_zero: assert property ( // R16
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (setup && !pwrite_i && hit(paddr_i, RCT_ADDR_MODE)) |=> (pready_o && !prdata_o[7]))
    else $error("load bit read back as one");

  a_frozen_count: assert property ( // R17
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (!mode_q[RCT_MC_EN] && !any_load) |=> $stable(cnt_q))
    else $error("counter moved while disabled");

  a_capture_value: assert property ( // R5
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cap_ev |=> (reload_q == $past(cnt_q)) && flags_q[RCT_FL_EDGE])
    else $error("capture value or edge flag wrong");

  a_capture_reset: assert property ( // R8
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (cap_rst && !wr_load && !load_rr) |=> (cnt_q == 8'h00) && (psc == '0))
    else $error("capture did not clear counter and prescaler");

  a_ext_edge_load: assert property ( // R10
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ext_ld && !wr_load) |=> (cnt_q == $past(reload_q)))
    else $error("external edge did not load counter");

  a_wrap_reload: assert property ( // R23
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    reload_ovf |=> (cnt_q == $past(reload_q)) && flags_q[RCT_FL_WRAP] && (psc == '0))
    else $error("auto-reload overflow wrong");

  a_flag_clear_06: assert property ( // R13
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_flags && wdat[2:0] == 3'h6 && !wrap_ev) |=>
      !flags_q[RCT_FL_WRAP] && (flags_q[2:1] == ($past(flags_q[2:1]) | $past(set_vec[2:1]))))
    else $error("flag write 06h disturbed other flags");

  a_pwm_match_low: assert property ( // R6
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (match_ev && mode_q[RCT_MC_PWM_OUT_ENABLE] && !wr_mode) |=> ##1 !pwm_out_pin_o)
    else $error("pin not low after match");

  a_pin_gated: assert property ( // R18
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !mode_q[RCT_MC_PWM_OUT_ENABLE] |=> !pwm_out_pin_o)
    else $error("pin driven while output disabled");

  a_irq_follows: assert property ( // R19
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ##1 (irq_o == |($past(flags_q) & $past(mode_q[RCT_MC_IRQ_HI:RCT_MC_IRQ_LO]))))
    else $error("interrupt request does not match flags and enables");

  a_same_rewrite: assert property ( // R15
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    same_rewrite |=> (cnt_q == $past(reload_q)) && (pwm_q == $past(pwm_q)) && (psc == '0))
    else $error("same-value rewrite did not restart the count");

  a_match_flag: assert property ( // R22
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (count_ev && (cnt_d == cmp_q)) |=> flags_q[RCT_FL_MATCH] && !pwm_q)
    else $error("match did not set flag and drive level low");

endmodule : rct_timer
`default_nettype wire

/* rct_pkg.sv */
// Package with register map, field positions and encodings of the reload/capture PWM timer.
//
// Function
// (R1) Compare above reload for a PWM pulse.
// (R2) Compare kept between reload value and 255.
// (R3) Write reload, then set load and enable.
// (R4) Auto-reload accepts internal, divided, external clock.
// (R5) Active edge captures counter, sets edge flag.
// (R6) Overflow sets PWM, match clears and flags.
// (R7) Capture modes use internal clocks only.
// (R8) Capture-with-reset clears counter and prescaler.
// (R9) Avoid reloading from FFh in capture-reset mode.
// (R10) External-load edge copies reload into counter.
// (R11) Do not change clock while counting.
// (R12) Every counter load clears the prescaler.
// (R13) Writing 06h clears only the wrap flag.
// (R14) Reset clears mode register, timer disabled.
// (R15) Same-value mode rewrite holds pin, restarts count; the code restarts only with enable and PWM output enable set.
// (R16) Load bit loads counter, reads zero.
// (R17) Enable bit runs; cleared freezes counter state.
// (R18) Output enable gates PWM onto pin.
// (R19) Interrupt while enable and flag both set.
// (R20) Mode field selects one of four modes.
// (R21) Flags cleared by writing zero.
// (R22) Flags set on edge, match, wrap.
// (R23) Auto-reload overflow reloads counter, sets PWM.
// (R24) Clock select picks source, 11 reserved.
// (R25) Edge control enables, picks rising or falling.
// (R26) Prescaler divides by two to the power.
// (R27) Event input synchronised before edge detection.
package rct_pkg;

  localparam int unsigned RCT_AW = 12;
  localparam int unsigned RCT_DW = 32;

  localparam logic [7:0] RCT_IDX_MODE   = 8'hd5;
  localparam logic [7:0] RCT_IDX_FLAGS  = 8'hd6;
  localparam logic [7:0] RCT_IDX_CLKCFG = 8'hd7;
  localparam logic [7:0] RCT_IDX_RELOAD = 8'hd9;
  localparam logic [7:0] RCT_IDX_CMP    = 8'hda;
  localparam logic [7:0] RCT_IDX_LOAD   = 8'hdb;

  localparam logic [RCT_AW-1:0] RCT_ADDR_MODE   = {2'h0, RCT_IDX_MODE, 2'h0};
  localparam logic [RCT_AW-1:0] RCT_ADDR_FLAGS  = {2'h0, RCT_IDX_FLAGS, 2'h0};
  localparam logic [RCT_AW-1:0] RCT_ADDR_CLKCFG = {2'h0, RCT_IDX_CLKCFG, 2'h0};
  localparam logic [RCT_AW-1:0] RCT_ADDR_RELOAD = {2'h0, RCT_IDX_RELOAD, 2'h0};
  localparam logic [RCT_AW-1:0] RCT_ADDR_CMP    = {2'h0, RCT_IDX_CMP, 2'h0};
  localparam logic [RCT_AW-1:0] RCT_ADDR_LOAD   = {2'h0, RCT_IDX_LOAD, 2'h0};

  localparam int unsigned RCT_MC_LOAD  = 7;
  localparam int unsigned RCT_MC_EN    = 6;
  localparam int unsigned RCT_MC_PWM_OUT_ENABLE = 5;
  localparam int unsigned RCT_MC_IRQ_HI = 4;
  localparam int unsigned RCT_MC_IRQ_LO = 2;
  localparam int unsigned RCT_FL_EDGE  = 2;
  localparam int unsigned RCT_FL_MATCH = 1;
  localparam int unsigned RCT_FL_WRAP  = 0;
  localparam int unsigned RCT_CC_PS_HI = 7;
  localparam int unsigned RCT_CC_PS_LO = 5;
  localparam int unsigned RCT_CC_POL   = 3;
  localparam int unsigned RCT_CC_EDGE  = 2;

  localparam logic [7:0] RCT_MODE_RST   = 8'h00;
  localparam logic [7:0] RCT_DATA_RST   = 8'h00;
  localparam logic [7:0] RCT_CNT_MAX    = 8'hff;
  localparam logic [2:0] RCT_FLAGS_RST  = 3'h0;
  localparam logic [1:0] RCT_DIV3_LAST  = 2'h2;

  typedef enum logic [1:0] {
    RCT_MODE_RELOAD  = 2'b00,
    RCT_MODE_CAPTURE = 2'b01,
    RCT_MODE_CAP_RST = 2'b10,
    RCT_MODE_EXT_LD  = 2'b11
  } rct_mode_t;

  typedef enum logic [1:0] {
    RCT_SRC_INT  = 2'b00,
    RCT_SRC_DIV3 = 2'b01,
    RCT_SRC_EXT  = 2'b10,
    RCT_SRC_RSV  = 2'b11
  } rct_src_t;

endpackage : rct_pkg

/* rct_edge_det.sv */
// Synchroniser and edge detector for the event input pin.
`timescale 1ns/1ps
`default_nettype none
module rct_edge_det (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  import rct_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // (R27) Two-stage synchroniser.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // (R27) One pulse per edge.
  assign rise_o = sync2_q & ~prev_q;
  assign fall_o = ~sync2_q & prev_q;

endmodule : rct_edge_det
`default_nettype wire

/* rct_prescaler.sv */
// Clock source multiplexer, divide-by-three stage and binary prescaler.
`timescale 1ns/1ps
`default_nettype none
module rct_prescaler #(
  parameter int unsigned PSC_W = 7
) (
  input  wire logic            clk_sys_i,
  input  wire logic            rst_n_i,
  input  wire logic            run_i,
  input  wire logic            clear_i,
  input  wire rct_pkg::rct_src_t src_i,
  input  wire logic [2:0]      ratio_i,
  input  wire logic            ext_tick_i,
  output logic                 tick_o,
  output logic [PSC_W-1:0]     psc_o
);
  import rct_pkg::*;

  logic [1:0]       div3_q;
  logic [PSC_W-1:0] psc_q;
  logic [PSC_W-1:0] mask;
  logic             src_tick;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div3_q <= 2'h0;
    end else if (div3_q == RCT_DIV3_LAST) begin
      div3_q <= 2'h0;
    end else begin
      div3_q <= div3_q + 2'h1;
    end
  end

  // (R4) Source selection.
  // (R24) Reserved code gives no clock.
  always_comb begin
    case (src_i)
      RCT_SRC_INT:  src_tick = 1'b1;
      RCT_SRC_DIV3: src_tick = (div3_q == RCT_DIV3_LAST);
      RCT_SRC_EXT:  src_tick = ext_tick_i;
      default:      src_tick = 1'b0;
    endcase
  end

  // (R26) Tap selects two to the power.
  assign mask   = PSC_W'((32'h1 << ratio_i) - 32'h1);
  assign tick_o = run_i & src_tick & ((psc_q & mask) == mask);
  assign psc_o  = psc_q;

  // (R17) Prescaler frozen when stopped.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psc_q <= '0;
    end else if (clear_i) begin
      psc_q <= '0;
    end else if (run_i && src_tick) begin
      psc_q <= psc_q + PSC_W'(1);
    end
  end

endmodule : rct_prescaler
`default_nettype wire

/* rct_pin_model.sv */
// Model of the far-side pins: event source and output watcher.
`timescale 1ns/1ps
`default_nettype none
module rct_pin_model (
  input  wire logic clk_sys_i,
  input  wire logic pwm_out_pin_i,
  output logic      event_in_pin_o
);

  initial event_in_pin_o = 1'b0;

  task automatic drive(input logic v);
    @(posedge clk_sys_i);
    event_in_pin_o <= v;
    repeat (4) @(posedge clk_sys_i);
  endtask : drive

  task automatic pulse();
    drive(1'b1);
    drive(1'b0);
  endtask : pulse

  // Waits for a high phase of the output and measures it in cycles.
  task automatic high_width(output int w);
    int n;
    n = 0;
    w = 0;
    while (pwm_out_pin_i !== 1'b1 && n < 400) begin
      @(negedge clk_sys_i);
      n++;
    end
    while (pwm_out_pin_i === 1'b1 && w < 400) begin
      @(negedge clk_sys_i);
      w++;
    end
  endtask : high_width

endmodule : rct_pin_model
`default_nettype wire

/* rct_timer_tb.sv */
// Self-checking testbench of the reload/capture PWM timer.
`timescale 1ns/1ps
`default_nettype none
module rct_timer_tb;
  import rct_pkg::*;

  logic              clk_sys_i;
  logic              rst_n_i;
  logic              psel_i;
  logic              penable_i;
  logic              pwrite_i;
  logic [RCT_AW-1:0] paddr_i;
  logic [RCT_DW-1:0] pwdata_i;
  logic [RCT_DW-1:0] prdata_o;
  logic              pready_o;
  logic              pslverr_o;
  logic              event_in_pin_i;
  logic              pwm_out_pin_o;
  logic              irq_o;
  int                error_cnt = 0;
  int                tests_run = 0;
  int                cyc       = 0;
  logic [RCT_DW-1:0] rd;
  logic              err;

  rct_timer #(.PSC_W(7)) u_rct_timer (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .event_in_pin_i(event_in_pin_i),
    .pwm_out_pin_o(pwm_out_pin_o), .irq_o(irq_o)
  );

  rct_pin_model u_rct_pin_model (
    .clk_sys_i(clk_sys_i), .pwm_out_pin_i(pwm_out_pin_o), .event_in_pin_o(event_in_pin_i)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high.
  task automatic apb(input logic wr, input logic [RCT_AW-1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= {24'h0, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1 && cyc < 20000) @(posedge clk_sys_i);
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [RCT_AW-1:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [RCT_AW-1:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 8'h00);
    chk(rd, e, m);
  endtask : rdchk

  // Runs the counter for n cycles from zero and checks the count range.
  task automatic run_cnt(input logic [7:0] cfg, input int n, input int lo, input int hi);
    wr(RCT_ADDR_CLKCFG, cfg);
    wr(RCT_ADDR_LOAD, 8'h00);
    wr(RCT_ADDR_MODE, 8'h40);
    repeat (n) @(posedge clk_sys_i);
    wr(RCT_ADDR_MODE, 8'h00);
    apb(1'b0, RCT_ADDR_LOAD, 8'h00);
    chk({31'h0, (rd >= lo && rd <= hi)}, 32'h1, "count range");
  endtask : run_cnt

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(RCT_ADDR_MODE, 32'h0, "mode reset");
    rdchk(RCT_ADDR_FLAGS, 32'h0, "flags reset");
    apb(1'b1, 12'h000, 8'hff);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
  endtask : t_reset

  task automatic t_count();
    logic [31:0] v;
    wr(RCT_ADDR_RELOAD, 8'h20);
    wr(RCT_ADDR_MODE, 8'h80);
    rdchk(RCT_ADDR_MODE, 32'h0, "load bit reads");
    rdchk(RCT_ADDR_LOAD, 32'h20, "load bit copy");
    run_cnt(8'h60, 80, 9, 11);
    v = rd;
    repeat (20) @(posedge clk_sys_i);
    rdchk(RCT_ADDR_LOAD, v, "frozen count");
    run_cnt(8'h01, 90, 29, 32);
    run_cnt(8'h03, 30, 0, 0);
    wr(RCT_ADDR_CLKCFG, 8'h02);
    wr(RCT_ADDR_LOAD, 8'h00);
    wr(RCT_ADDR_MODE, 8'h40);
    repeat (3) u_rct_pin_model.pulse();
    wr(RCT_ADDR_MODE, 8'h00);
    rdchk(RCT_ADDR_LOAD, 32'h3, "external clock");
    $display("test count done");
  endtask : t_count

  task automatic t_pwm();
    int w;
    int hi;
    wr(RCT_ADDR_CLKCFG, 8'h00);
    wr(RCT_ADDR_RELOAD, 8'hf0);
    wr(RCT_ADDR_CMP, 8'hf8);
    wr(RCT_ADDR_FLAGS, 8'h00);
    wr(RCT_ADDR_MODE, 8'he4);
    u_rct_pin_model.high_width(w);
    chk(w, 32'd8, "high time");
    wr(RCT_ADDR_MODE, 8'h24);
    rdchk(RCT_ADDR_FLAGS, 32'h3, "wrap and match");
    chk({31'h0, irq_o}, 32'h1, "wrap irq");
    wr(RCT_ADDR_FLAGS, 8'h06);
    rdchk(RCT_ADDR_FLAGS, 32'h2, "wrap cleared");
    chk({31'h0, irq_o}, 32'h0, "irq masked");
    wr(RCT_ADDR_MODE, 8'hc0);
    hi = 0;
    repeat (60) begin
      @(negedge clk_sys_i);
      hi += int'(pwm_out_pin_o !== 1'b0);
    end
    chk(hi, 32'd0, "output disabled");
    wr(RCT_ADDR_MODE, 8'h00);
    wr(RCT_ADDR_CLKCFG, 8'he0);
    wr(RCT_ADDR_MODE, 8'he4);
    repeat (130) @(posedge clk_sys_i);
    wr(RCT_ADDR_MODE, 8'h64);
    rdchk(RCT_ADDR_LOAD, 32'hf0, "rewrite restart");
    repeat (120) @(posedge clk_sys_i);
    rdchk(RCT_ADDR_LOAD, 32'hf0, "prescaler cleared");
    wr(RCT_ADDR_MODE, 8'h00);
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_edge();
    wr(RCT_ADDR_CLKCFG, 8'h04);
    wr(RCT_ADDR_LOAD, 8'h42);
    wr(RCT_ADDR_MODE, 8'h11);
    wr(RCT_ADDR_FLAGS, 8'h00);
    u_rct_pin_model.pulse();
    rdchk(RCT_ADDR_RELOAD, 32'h42, "capture");
    rdchk(RCT_ADDR_FLAGS, 32'h4, "edge flag");
    chk({31'h0, irq_o}, 32'h1, "edge irq");
    wr(RCT_ADDR_MODE, 8'h12);
    wr(RCT_ADDR_LOAD, 8'h55);
    u_rct_pin_model.pulse();
    rdchk(RCT_ADDR_LOAD, 32'h0, "capture reset");
    rdchk(RCT_ADDR_RELOAD, 32'h55, "capture value");
    wr(RCT_ADDR_MODE, 8'h13);
    wr(RCT_ADDR_RELOAD, 8'h33);
    u_rct_pin_model.pulse();
    rdchk(RCT_ADDR_LOAD, 32'h33, "edge load");
    wr(RCT_ADDR_CLKCFG, 8'h0c);
    wr(RCT_ADDR_LOAD, 8'h00);
    u_rct_pin_model.drive(1'b1);
    rdchk(RCT_ADDR_LOAD, 32'h0, "rise ignored");
    u_rct_pin_model.drive(1'b0);
    rdchk(RCT_ADDR_LOAD, 32'h33, "fall loads");
    wr(RCT_ADDR_CLKCFG, 8'h00);
    wr(RCT_ADDR_FLAGS, 8'h00);
    wr(RCT_ADDR_LOAD, 8'h11);
    u_rct_pin_model.pulse();
    rdchk(RCT_ADDR_LOAD, 32'h11, "detect off");
    rdchk(RCT_ADDR_FLAGS, 32'h0, "no edge flag");
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdchk(RCT_ADDR_MODE, 32'h0, "mode after reset");
    $display("test edge done");
  endtask : t_edge

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i   = 1'b0;
    psel_i    = 1'b0;
    penable_i = 1'b0;
    pwrite_i  = 1'b0;
    paddr_i   = '0;
    pwdata_i  = '0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_count();
    t_pwm();
    t_edge();
    results();
  end

endmodule : rct_timer_tb
`default_nettype wire
